//--- include/pofc_pkg.sv
/*
 * Shared constants and types for the enable-source and fault-clear block.
 * Assumes a single 50 MHz device clock and command strobes already decoded
 * by a PMBus protocol engine on the same clock.
 */
package pofc_pkg;

   // Command codes handled here.
   localparam logic [7:0] POFC_CMD_ENABLE_SOURCE_CONFIG = 8'h02;
   localparam logic [7:0] POFC_CMD_FAULT_CLEAR = 8'h03;

   // Field positions of the enable-source configuration byte.
   localparam int POFC_BIT_TURN_OFF_PROFILE = 0;
   localparam int POFC_BIT_PIN_POLARITY = 1;
   localparam int POFC_BIT_PIN_SOURCE = 2;
   localparam int POFC_BIT_CMD_SOURCE = 3;
   localparam int POFC_BIT_POWER_UP_SOURCE = 4;
   localparam int POFC_CFG_WIDTH = 5;
   localparam logic [2:0] POFC_CFG_RESERVED_VALUE = 3'h0;

   // Configuration value before the nonvolatile copy arrives.
   localparam logic [POFC_CFG_WIDTH-1:0] POFC_CFG_RESET = 5'h00;

   // Operation command on/off bit position.
   localparam int POFC_BIT_OPERATION_ON = 7;

   // Phase selection.
   localparam int POFC_NUM_PHASES = 4;
   localparam int POFC_STATUS_BITS = 8;
   localparam logic [7:0] POFC_PHASE_BROADCAST = 8'hff;

   // Turn-off hold and ramp times arrive as cycle counts of this width.
   localparam int POFC_TIME_WIDTH = 16;

   // Error codes on the response port.
   localparam logic [1:0] POFC_RSP_OK = 2'h0;
   localparam logic [1:0] POFC_RSP_INVALID_DATA = 2'h1;
   localparam logic [1:0] POFC_RSP_UNSUPPORTED = 2'h2;

   // Conversion sequencer states, Gray coded along idle-run-hold-ramp.
   typedef enum logic [1:0]
   {
      POFC_ST_IDLE = 2'b00,
      POFC_ST_RUN = 2'b01,
      POFC_ST_HOLD = 2'b11,
      POFC_ST_RAMP = 2'b10
   } pofc_state_type;

   typedef logic [POFC_NUM_PHASES*POFC_STATUS_BITS-1:0] pofc_status_type;

endpackage

//--- include/pofc_ctl_if.sv
/*
 * Carrier between the top of the block and its status keeper.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface pofc_ctl_if;
   import pofc_pkg::*;

   logic clear_stb;
   logic [POFC_NUM_PHASES-1:0] clear_phase_mask;
   logic ara_done_stb;
   logic invalid_stb;
   logic restart_stb;
   pofc_status_type fault_src;
   pofc_status_type status;
   logic cml;
   logic alert;

   modport ctl
   (
      output clear_stb, clear_phase_mask, ara_done_stb, invalid_stb, restart_stb, fault_src,
      input status, cml, alert
   );
   modport keep
   (
      input clear_stb, clear_phase_mask, ara_done_stb, invalid_stb, restart_stb, fault_src,
      output status, cml, alert
   );
endinterface

//--- core/pofc_pin_sync.sv
/*
 * Two-stage synchroniser for the enable/lockout pin and the lockout comparator.
 * Assumes both inputs are asynchronous levels from outside the clock domain.
 */
`timescale 1ns/10ps
module pofc_pin_sync
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [1:0] async_in,
   output logic [1:0] sync_out
);
   logic [1:0] stage1_ff;
   logic [1:0] stage2_ff;

   // The first stage feeds only the second, so metastability never fans out.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         stage1_ff <= 2'h0;
         stage2_ff <= 2'h0;
      end
      else
      begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;
endmodule

//--- core/pofc_fault_status.sv
/*
 * Per-phase status bits, communication error bit and alert generation.
 * Assumes fault sources are same-clock levels and commands arrive as pulses.
 */
`timescale 1ns/10ps
module pofc_fault_status
(
   input wire logic clk_in,
   input wire logic resetn_in,
   pofc_ctl_if.keep ctl
);
   import pofc_pkg::*;

   pofc_status_type status_ff;
   pofc_status_type blocked_ff;
   logic cml_ff;
   logic alert_ff;
   pofc_status_type clear_bits;
   pofc_status_type nxt_status;
   pofc_status_type nxt_blocked;
   pofc_status_type fresh_bits;
   logic nxt_cml;
   logic nxt_alert;
   logic cml_fresh;

   // Widen the phase mask to one bit per status bit.
   always_comb
   begin
      clear_bits = '0;
      for (int p = 0; p < POFC_NUM_PHASES; p++)
      begin
         if (ctl.clear_stb && ctl.clear_phase_mask[p])
         begin
            clear_bits[p*POFC_STATUS_BITS +: POFC_STATUS_BITS] = {POFC_STATUS_BITS{1'b1}};
         end
      end
   end

   // A source still active in the clearing cycle sets its bit again at once.
   assign nxt_status = (status_ff & ~clear_bits) | ctl.fault_src;
   assign nxt_cml = (cml_ff & ~ctl.clear_stb) | ctl.invalid_stb;
   // Bits that were latched when the alert was answered stay blocked until cleared or until the sequencer restarts from idle.
   assign nxt_blocked = ctl.restart_stb ? '0
                      : ((blocked_ff & ~clear_bits) | (ctl.ara_done_stb ? status_ff : '0));
   assign fresh_bits = nxt_status & ~(status_ff & ~clear_bits) & ~nxt_blocked;
   assign cml_fresh = ctl.invalid_stb & ~cml_ff;
   // New events win over a release landing in the same cycle.
   assign nxt_alert = (|fresh_bits) | cml_fresh
                    | (alert_ff & ~ctl.clear_stb & ~ctl.ara_done_stb);

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         status_ff <= '0;
         blocked_ff <= '0;
         cml_ff <= 1'b0;
         alert_ff <= 1'b0;
      end
      else
      begin
         status_ff <= nxt_status;
         blocked_ff <= nxt_blocked;
         cml_ff <= nxt_cml;
         alert_ff <= nxt_alert;
      end
   end

   assign ctl.status = status_ff;
   assign ctl.cml = cml_ff;
   assign ctl.alert = alert_ff;
endmodule

//--- core/pofc_top.sv
/*
 * Enable-source configuration, conversion on/off sequencing and fault clearing.
 * Assumes a PMBus protocol engine on MCLK_IN delivers decoded command pulses,
 * that fault sources and the operation on bit are same-clock levels, and that
 * the enable/lockout pin and its lockout comparator are asynchronous.
 */
`timescale 1ns/10ps

// Contract
// - Top three config bits read zero, read-only.
// - Power-up bit clear: start whenever input present.
// - Power-up bit set: obey pin and command.
// - Command-source bit selects operation command use.
// - Pin-source clear: ignore pin, lockout disabled.
// - Pin-source set: use pin, plus command.
// - Polarity bit: clear active low, set high.
// - Profile clear: hold, then ramp to zero.
// - Profile set: pin off stops at once.
// - Enable/lockout pin is the control pin.
// - Unlisted config value rejected as invalid data.
// - Fault clear is data-less, write-only, no readback.
// - Fault clear wipes selected or all phases.
// - Fault clear also releases the alert line.
// - Fault clear never restarts latched-off output.
// - Persisting fault sets again and alerts.
// - Answered alert response releases alert, keeps bits.
// - Pre-answer faults stay silent until cleared.
// - Operation on bit counts only when configured.
// - Phase selector all ones addresses every phase.
module pofc_top
(
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic CMD_STB_IN,
   input wire logic [7:0] CMD_CODE_IN,
   input wire logic CMD_READ_IN,
   input wire logic CMD_HAS_DATA_IN,
   input wire logic [7:0] CMD_DATA_IN,
   input wire logic [7:0] PHASE_SEL_IN,
   input wire logic ARA_DONE_IN,
   input wire logic NVM_LOAD_IN,
   input wire logic [pofc_pkg::POFC_CFG_WIDTH-1:0] NVM_CFG_IN,
   input wire logic ENABLE_LOCKOUT_PIN_IN,
   input wire logic LOCKOUT_OK_IN,
   input wire logic INPUT_POWER_OK_IN,
   input wire logic [7:0] OPERATION_IN,
   input wire logic FAULT_LATCHED_OFF_IN,
   input wire logic [pofc_pkg::POFC_TIME_WIDTH-1:0] TURN_OFF_HOLD_TIME_IN,
   input wire logic [pofc_pkg::POFC_TIME_WIDTH-1:0] TURN_OFF_RAMP_TIME_IN,
   input wire pofc_pkg::pofc_status_type FAULT_SRC_IN,
   output logic RSP_STB_OUT,
   output logic [7:0] RSP_DATA_OUT,
   output logic [1:0] RSP_ERR_OUT,
   output logic [7:0] CONFIG_OUT,
   output logic CONVERT_OUT,
   output logic RAMP_DOWN_OUT,
   output logic SMBALERT_N_OUT,
   output logic SMBALERT_OE_OUT,
   output pofc_pkg::pofc_status_type STATUS_OUT,
   output logic CML_OUT
);
   import pofc_pkg::*;

   pofc_ctl_if ctl_bus();

   logic [POFC_CFG_WIDTH-1:0] cfg_ff;
   logic [POFC_CFG_WIDTH-1:0] nxt_cfg;
   logic rsp_stb_ff;
   logic [7:0] rsp_data_ff;
   logic [1:0] rsp_err_ff;
   logic [7:0] nxt_rsp_data;
   logic [1:0] nxt_rsp_err;
   pofc_state_type state_ff;
   pofc_state_type nxt_state;
   logic [POFC_TIME_WIDTH-1:0] count_ff;
   logic [POFC_TIME_WIDTH-1:0] nxt_count;
   logic convert_ff;
   logic ramp_ff;
   logic alert_n_ff;
   logic [1:0] pin_sync;
   logic pin_level;
   logic lockout_ok;

   // Named decode of the incoming command.
   logic hit_cfg;
   logic hit_clear;
   logic cfg_write;
   logic cfg_read;
   logic cfg_value_ok;
   logic cfg_write_ok;
   logic cfg_write_bad;
   logic clear_ok;
   logic phase_ok;
   logic [POFC_NUM_PHASES-1:0] phase_mask;
   logic cmd_error;
   logic cmd_unsupported;

   // Named decode of the enable-source configuration.
   logic use_controls;
   logic use_cmd;
   logic use_pin;
   logic pin_active_high;
   logic immediate_off;
   logic pin_active;
   logic pin_says_on;
   logic cmd_says_on;
   logic want_on;
   logic pin_off_event;
   logic fault_stop;

   // Maps a phase selector to the phases it addresses; broadcast reaches all.
   function automatic logic [POFC_NUM_PHASES-1:0] phase_decode(input logic [7:0] sel);
      logic [POFC_NUM_PHASES-1:0] mask;
      mask = '0;
      if (sel == POFC_PHASE_BROADCAST)
      begin
         mask = {POFC_NUM_PHASES{1'b1}};
      end
      else if (sel < 8'(POFC_NUM_PHASES))
      begin
         mask[sel[1:0]] = 1'b1;
      end
      return mask;
   endfunction

   // The control pin and its lockout comparator are asynchronous to the clock.
   pofc_pin_sync u_pin_sync
   (
      .clk_in(MCLK_IN),
      .resetn_in(RESETN_IN),
      .async_in({LOCKOUT_OK_IN, ENABLE_LOCKOUT_PIN_IN}),
      .sync_out(pin_sync)
   );

   assign pin_level = pin_sync[0];
   assign lockout_ok = pin_sync[1];

   // Status bits and alert live in their own keeper.
   pofc_fault_status u_fault_status
   (
      .clk_in(MCLK_IN),
      .resetn_in(RESETN_IN),
      .ctl(ctl_bus.keep)
   );

   // Command decode; reads and writes share one strobe from the protocol engine.
   assign hit_cfg = CMD_STB_IN && (CMD_CODE_IN == POFC_CMD_ENABLE_SOURCE_CONFIG);
   assign hit_clear = CMD_STB_IN && (CMD_CODE_IN == POFC_CMD_FAULT_CLEAR);
   assign cfg_write = hit_cfg && !CMD_READ_IN && CMD_HAS_DATA_IN;
   assign cfg_read = hit_cfg && CMD_READ_IN;
   // Every combination of the low five bits is listed; only the top bits can be wrong.
   assign cfg_value_ok = (CMD_DATA_IN[7:5] == POFC_CFG_RESERVED_VALUE);
   assign cfg_write_ok = cfg_write && cfg_value_ok;
   assign cfg_write_bad = cfg_write && !cfg_value_ok;
   // Fault clear is a send-byte: no data, no read form.
   assign clear_ok = hit_clear && !CMD_READ_IN && !CMD_HAS_DATA_IN;
   assign phase_mask = phase_decode(PHASE_SEL_IN);
   assign phase_ok = |phase_mask;
   assign cmd_unsupported = (hit_clear && CMD_READ_IN)
                          || (hit_cfg && !CMD_READ_IN && !CMD_HAS_DATA_IN)
                          || (CMD_STB_IN && !hit_cfg && !hit_clear);
   assign cmd_error = cfg_write_bad || (hit_clear && !clear_ok) || (clear_ok && !phase_ok)
                    || cmd_unsupported;

   // Response data and error code for the protocol engine.
   assign nxt_rsp_data = cfg_read ? {POFC_CFG_RESERVED_VALUE, cfg_ff} : 8'h00;
   assign nxt_rsp_err = cmd_unsupported ? POFC_RSP_UNSUPPORTED
                      : (cmd_error ? POFC_RSP_INVALID_DATA : POFC_RSP_OK);

   // Host writes update on the fly; the stored copy arrives once after power-up.
   assign nxt_cfg = cfg_write_ok ? CMD_DATA_IN[POFC_CFG_WIDTH-1:0]
                  : (NVM_LOAD_IN ? NVM_CFG_IN : cfg_ff);

   // Drive the status keeper.
   assign ctl_bus.clear_stb = clear_ok && phase_ok;
   assign ctl_bus.clear_phase_mask = phase_mask;
   assign ctl_bus.ara_done_stb = ARA_DONE_IN;
   assign ctl_bus.invalid_stb = CMD_STB_IN && cmd_error;
   assign ctl_bus.restart_stb = (state_ff == POFC_ST_IDLE) && (nxt_state == POFC_ST_RUN);
   assign ctl_bus.fault_src = FAULT_SRC_IN;

   // Configuration field decode.
   assign use_controls = cfg_ff[POFC_BIT_POWER_UP_SOURCE];
   assign use_cmd = cfg_ff[POFC_BIT_CMD_SOURCE];
   assign use_pin = cfg_ff[POFC_BIT_PIN_SOURCE];
   assign pin_active_high = cfg_ff[POFC_BIT_PIN_POLARITY];
   assign immediate_off = cfg_ff[POFC_BIT_TURN_OFF_PROFILE];

   // Lockout only qualifies an active-high pin; active low leaves it unusable.
   assign pin_active = pin_active_high ? (pin_level && lockout_ok) : !pin_level;
   // An ignored pin counts as on, which also takes the lockout out of play.
   assign pin_says_on = use_pin ? pin_active : 1'b1;
   assign cmd_says_on = use_cmd ? OPERATION_IN[POFC_BIT_OPERATION_ON] : 1'b1;
   // Without the power-up bit only input power matters.
   assign want_on = INPUT_POWER_OK_IN
                  && (!use_controls || (pin_says_on && cmd_says_on));
   // A pin-driven turn-off gets the profile; other stops are immediate.
   assign pin_off_event = use_controls && use_pin && !pin_active && cmd_says_on
                        && INPUT_POWER_OK_IN;
   // Latched-off faults are owned outside; clearing status never lifts them.
   assign fault_stop = FAULT_LATCHED_OFF_IN;

   // Conversion sequencer next state.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      case (state_ff)
         POFC_ST_IDLE:
         begin
            if (want_on && !fault_stop)
            begin
               nxt_state = POFC_ST_RUN;
            end
         end
         POFC_ST_RUN:
         begin
            if (fault_stop || (!want_on && !pin_off_event))
            begin
               nxt_state = POFC_ST_IDLE;
            end
            else if (pin_off_event && immediate_off)
            begin
               nxt_state = POFC_ST_IDLE;
            end
            else if (pin_off_event)
            begin
               nxt_state = POFC_ST_HOLD;
               nxt_count = TURN_OFF_HOLD_TIME_IN;
            end
         end
         POFC_ST_HOLD:
         begin
            // Keep regulating for the hold time, then ramp for the fall time.
            if (fault_stop || !INPUT_POWER_OK_IN)
            begin
               nxt_state = POFC_ST_IDLE;
            end
            else if (count_ff == '0)
            begin
               nxt_state = POFC_ST_RAMP;
               nxt_count = TURN_OFF_RAMP_TIME_IN;
            end
            else
            begin
               nxt_count = count_ff - 1'b1;
            end
         end
         POFC_ST_RAMP:
         begin
            // A turn-off in progress runs to zero before a new start is allowed.
            if (fault_stop || !INPUT_POWER_OK_IN || count_ff == '0)
            begin
               nxt_state = POFC_ST_IDLE;
            end
            else
            begin
               nxt_count = count_ff - 1'b1;
            end
         end
         default:
         begin
            nxt_state = POFC_ST_IDLE;
         end
      endcase
   end

   // Configuration store.
   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         cfg_ff <= POFC_CFG_RESET;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Response port registers.
   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         rsp_stb_ff <= 1'b0;
         rsp_data_ff <= 8'h00;
         rsp_err_ff <= POFC_RSP_OK;
      end
      else
      begin
         rsp_stb_ff <= CMD_STB_IN;
         rsp_data_ff <= nxt_rsp_data;
         rsp_err_ff <= nxt_rsp_err;
      end
   end

   // Sequencer registers.
   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         state_ff <= POFC_ST_IDLE;
         count_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
      end
   end

   // Power stage drive is registered so the outputs never glitch on decode.
   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         convert_ff <= 1'b0;
         ramp_ff <= 1'b0;
         alert_n_ff <= 1'b1;
      end
      else
      begin
         convert_ff <= (nxt_state != POFC_ST_IDLE);
         ramp_ff <= (nxt_state == POFC_ST_RAMP);
         alert_n_ff <= !ctl_bus.alert;
      end
   end

   // Outputs; status and error bits are flip-flops inside the keeper.
   assign RSP_STB_OUT = rsp_stb_ff;
   assign RSP_DATA_OUT = rsp_data_ff;
   assign RSP_ERR_OUT = rsp_err_ff;
   assign CONFIG_OUT = {POFC_CFG_RESERVED_VALUE, cfg_ff};
   assign CONVERT_OUT = convert_ff;
   assign RAMP_DOWN_OUT = ramp_ff;
   // Open-drain alert: pull low only while asserted, otherwise release.
   assign SMBALERT_N_OUT = alert_n_ff;
   assign SMBALERT_OE_OUT = !alert_n_ff;
   assign STATUS_OUT = ctl_bus.status;
   assign CML_OUT = ctl_bus.cml;
endmodule

//--- testbench/pofc_properties.sv
/*
 * Concurrent checks on the ports of the enable-source and fault-clear block.
 * Assumes it is bound into every pofc_top and shares its clock and reset.
 */
`timescale 1ns/10ps
module pofc_checker
(
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic CMD_STB_IN,
   input wire logic [7:0] CMD_CODE_IN,
   input wire logic CMD_READ_IN,
   input wire logic CMD_HAS_DATA_IN,
   input wire logic [7:0] CMD_DATA_IN,
   input wire logic [7:0] PHASE_SEL_IN,
   input wire logic ARA_DONE_IN,
   input wire logic INPUT_POWER_OK_IN,
   input wire logic FAULT_LATCHED_OFF_IN,
   input wire pofc_pkg::pofc_status_type FAULT_SRC_IN,
   input wire logic RSP_STB_OUT,
   input wire logic [1:0] RSP_ERR_OUT,
   input wire logic [7:0] CONFIG_OUT,
   input wire logic CONVERT_OUT,
   input wire logic SMBALERT_N_OUT,
   input wire pofc_pkg::pofc_status_type STATUS_OUT
);
   import pofc_pkg::*;

   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);

   // Decoded command kinds, so each property reads as the rule it keeps.
   logic is_cfg_wr;
   logic is_clr_all;
   logic no_src;
   assign is_cfg_wr = CMD_STB_IN && CMD_CODE_IN == 8'h02 && !CMD_READ_IN && CMD_HAS_DATA_IN;
   assign is_clr_all = CMD_STB_IN && CMD_CODE_IN == 8'h03 && !CMD_READ_IN && !CMD_HAS_DATA_IN
      && PHASE_SEL_IN == 8'hff;
   assign no_src = FAULT_SRC_IN == '0;

   property p_rsv_zero;
      CONFIG_OUT[7:5] == 3'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved config bits set");
   property p_cfg_wr;
      is_cfg_wr && CMD_DATA_IN[7:5] == 3'h0 |=> CONFIG_OUT == {3'h0, $past(CMD_DATA_IN[4:0])};
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
   property p_bad_cfg;
      is_cfg_wr && CMD_DATA_IN[7:5] != 3'h0 |=> RSP_ERR_OUT == 2'h1 && $stable(CONFIG_OUT);
   endproperty
   a_bad_cfg: assert property (p_bad_cfg) else $error("bad config accepted");
   property p_clr_wo;
      CMD_STB_IN && CMD_CODE_IN == 8'h03 && CMD_READ_IN |=> RSP_STB_OUT && RSP_ERR_OUT == 2'h2;
   endproperty
   a_clr_wo: assert property (p_clr_wo) else $error("fault clear read answered");
   property p_clr_all;
      is_clr_all && no_src |=> STATUS_OUT == '0;
   endproperty
   a_clr_all: assert property (p_clr_all) else $error("status not cleared");
   property p_clr_alert;
      is_clr_all && no_src && !$past(CMD_STB_IN) |=> ##1 SMBALERT_N_OUT;
   endproperty
   a_clr_alert: assert property (p_clr_alert) else $error("alert kept after clear");
   property p_src_sets;
      1'b1 |=> (STATUS_OUT & $past(FAULT_SRC_IN)) == $past(FAULT_SRC_IN);
   endproperty
   a_src_sets: assert property (p_src_sets) else $error("fault bit not set");
   property p_ara;
      ARA_DONE_IN && no_src && !CMD_STB_IN ##1 no_src && !CMD_STB_IN
         |=> SMBALERT_N_OUT && $stable(STATUS_OUT);
   endproperty
   a_ara: assert property (p_ara) else $error("alert answer mishandled");
   property p_pu_on;
      INPUT_POWER_OK_IN && !CONFIG_OUT[4] && !FAULT_LATCHED_OFF_IN |=> ##[0:3] CONVERT_OUT;
   endproperty
   a_pu_on: assert property (p_pu_on) else $error("no start with power");
   property p_latched;
      FAULT_LATCHED_OFF_IN && $past(FAULT_LATCHED_OFF_IN) && !CONVERT_OUT |=> !CONVERT_OUT;
   endproperty
   a_latched: assert property (p_latched) else $error("latched output restarted");
endmodule

bind pofc_top pofc_checker u_chk (.MCLK_IN, .RESETN_IN, .CMD_STB_IN, .CMD_CODE_IN, .CMD_READ_IN,
   .CMD_HAS_DATA_IN, .CMD_DATA_IN, .PHASE_SEL_IN, .ARA_DONE_IN, .INPUT_POWER_OK_IN,
   .FAULT_LATCHED_OFF_IN, .FAULT_SRC_IN, .RSP_STB_OUT, .RSP_ERR_OUT, .CONFIG_OUT, .CONVERT_OUT,
   .SMBALERT_N_OUT, .STATUS_OUT);

//--- testbench/pofc_host_model.sv
/*
 * Host side of the decoded command port: raises one command, takes the answer.
 * Assumes the answer strobe is registered on the taking edge itself and read just after it.
 */
`timescale 1ns/10ps
module pofc_host_model
(
   input wire logic clk_in,
   input wire logic rsp_stb_in,
   input wire logic [7:0] rsp_data_in,
   input wire logic [1:0] rsp_err_in,
   output logic cmd_stb_out,
   output logic [7:0] cmd_code_out,
   output logic cmd_read_out,
   output logic cmd_has_data_out,
   output logic [7:0] cmd_data_out
);
   // Idle lines start at a pattern nobody should rely on.
   initial
   begin
      cmd_stb_out = 1'b0;
      cmd_code_out = 8'h5a;
      cmd_read_out = 1'b1;
      cmd_has_data_out = 1'b1;
      cmd_data_out = 8'ha5;
   end

   // Code and data lines are inverted after use so a stale value can never pass as fresh.
   task automatic xfer(input logic [7:0] code, input logic rd, input logic hd,
      input logic [7:0] dat, output logic [7:0] q, output logic [1:0] e, output logic ok);
      @(posedge clk_in);
      #1;
      cmd_stb_out = 1'b1;
      cmd_code_out = code;
      cmd_read_out = rd;
      cmd_has_data_out = hd;
      cmd_data_out = dat;
      @(posedge clk_in);
      #1;
      ok = rsp_stb_in;
      q = rsp_data_in;
      e = rsp_err_in;
      cmd_stb_out = 1'b0;
      cmd_code_out = ~code;
      cmd_data_out = ~dat;
   endtask
endmodule

//--- testbench/tb.sv
/*
 * Self-checking bench for pofc_top: configuration, on/off and fault clearing.
 * Assumes the host model owns the command port and the bench the levels.
 */
`timescale 1ns/10ps
module tb;
   import pofc_pkg::*;

   logic clk, rst_n, stb, rd, hd, ara, nvm_ld, pin, lok, pwr, latched, ok;
   logic rsp_stb, conv, ramp, alert_n, alert_oe, cml;
   logic [7:0] code, dat, ph, op, rsp_data, cfg, last_q;
   logic [1:0] rsp_err, e;
   logic [4:0] nvm_cfg;
   logic [15:0] hold_t, ramp_t;
   pofc_status_type src, status;
   logic [8:0] tbl [13];
   int n_fail, checks_done, k;

   pofc_top DUT (.MCLK_IN(clk), .RESETN_IN(rst_n), .CMD_STB_IN(stb), .CMD_CODE_IN(code),
      .CMD_READ_IN(rd), .CMD_HAS_DATA_IN(hd), .CMD_DATA_IN(dat), .PHASE_SEL_IN(ph),
      .ARA_DONE_IN(ara), .NVM_LOAD_IN(nvm_ld), .NVM_CFG_IN(nvm_cfg),
      .ENABLE_LOCKOUT_PIN_IN(pin), .LOCKOUT_OK_IN(lok), .INPUT_POWER_OK_IN(pwr),
      .OPERATION_IN(op), .FAULT_LATCHED_OFF_IN(latched), .TURN_OFF_HOLD_TIME_IN(hold_t),
      .TURN_OFF_RAMP_TIME_IN(ramp_t), .FAULT_SRC_IN(src), .RSP_STB_OUT(rsp_stb),
      .RSP_DATA_OUT(rsp_data), .RSP_ERR_OUT(rsp_err), .CONFIG_OUT(cfg), .CONVERT_OUT(conv),
      .RAMP_DOWN_OUT(ramp), .SMBALERT_N_OUT(alert_n), .SMBALERT_OE_OUT(alert_oe),
      .STATUS_OUT(status), .CML_OUT(cml));
   pofc_host_model host (.clk_in(clk), .rsp_stb_in(rsp_stb), .rsp_data_in(rsp_data),
      .rsp_err_in(rsp_err), .cmd_stb_out(stb), .cmd_code_out(code), .cmd_read_out(rd),
      .cmd_has_data_out(hd), .cmd_data_out(dat));

   // Every comparison is counted; a mismatch is reported at once.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One command through the host; the answer strobe and code are always checked.
   task automatic cmd(input logic [7:0] c, input logic r, input logic h, input logic [7:0] d,
      input logic [1:0] exp_err);
      host.xfer(c, r, h, d, last_q, e, ok);
      chk("answer strobe", 1, ok);
      chk("answer code", exp_err, e);
   endtask

   // Free-running device clock at 50 MHz.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Each table row is config bits, pin, lockout ok, operation on, expected conversion.
   initial
   begin
      tbl = '{{5'h00, 4'b0001}, {5'h17, 4'b1101}, {5'h17, 4'b0100}, {5'h17, 4'b1000},
         {5'h15, 4'b0101}, {5'h15, 4'b1100}, {5'h13, 4'b0001}, {5'h19, 4'b0011},
         {5'h19, 4'b0000}, {5'h11, 4'b0001}, {5'h1f, 4'b1111}, {5'h1f, 4'b1100},
         {5'h1f, 4'b0110}};
      rst_n = 1'b0;
      ara = 1'b0;
      nvm_ld = 1'b0;
      nvm_cfg = 5'h17;
      pin = 1'b0;
      lok = 1'b1;
      pwr = 1'b1;
      op = 8'h00;
      latched = 1'b0;
      hold_t = 16'h0003;
      ramp_t = 16'h0002;
      src = '0;
      ph = 8'hff;
      n_fail = 0;
      checks_done = 0;
      cyc(2);
      rst_n = 1'b1;
      chk("config at reset", 8'h00, cfg);
      chk("alert at reset", 1, alert_n);
      nvm_ld = 1'b1;
      cyc(1);
      nvm_ld = 1'b0;
      cyc(1);
      chk("config from storage", 8'h17, cfg);
      cmd(8'h02, 1'b1, 1'b0, 8'h00, POFC_RSP_OK);
      chk("config readback", 8'h17, last_q);
      foreach (tbl[i])
      begin
         pin = tbl[i][3];
         lok = tbl[i][2];
         op = {tbl[i][1], 7'h00};
         cmd(8'h02, 1'b0, 1'b1, {3'h0, tbl[i][8:4]}, POFC_RSP_OK);
         cyc(6);
         chk("conversion", tbl[i][0], conv);
      end
      // Soft turn-off: hold, then a ramp of exactly ramp time plus one cycles.
      pin = 1'b1;
      cmd(8'h02, 1'b0, 1'b1, 8'h16, POFC_RSP_OK);
      cyc(6);
      chk("conversion before soft off", 1, conv);
      pin = 1'b0;
      k = 0;
      while (!ramp && k < 50)
      begin
         chk("held while waiting", 1, conv);
         cyc(1);
         k++;
      end
      chk("hold length", 1, k >= hold_t + 1 && k <= hold_t + 5);
      k = 0;
      while (ramp && k < 50)
      begin
         cyc(1);
         k++;
      end
      chk("ramp length", ramp_t + 1, k);
      chk("stopped after ramp", 0, conv);
      // Refused commands all flag the communication bit.
      cmd(8'h02, 1'b0, 1'b1, 8'he0, POFC_RSP_INVALID_DATA);
      chk("config kept", 8'h16, cfg);
      chk("comm bit", 1, cml);
      cmd(8'h03, 1'b1, 1'b0, 8'h00, POFC_RSP_UNSUPPORTED);
      cmd(8'h03, 1'b0, 1'b1, 8'h00, POFC_RSP_INVALID_DATA);
      ph = 8'h05;
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_INVALID_DATA);
      ph = 8'hff;
      cyc(2);
      chk("alert on invalid", 2'b01, {alert_n, alert_oe});
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_OK);
      chk("comm bit cleared", 0, cml);
      cyc(1);
      chk("alert released", 1, alert_n);
      // Alert, alert answer, blocked refire, then a fresh source.
      src[9] = 1'b1;
      cyc(3);
      chk("fault bit", 1, status[9]);
      chk("alert on fault", 0, alert_n);
      src[9] = 1'b0;
      ara = 1'b1;
      cyc(1);
      ara = 1'b0;
      cyc(1);
      chk("alert after answer", 1, alert_n);
      chk("bit kept after answer", 1, status[9]);
      src[9] = 1'b1;
      cyc(3);
      src[9] = 1'b0;
      chk("blocked source silent", 1, alert_n);
      src[0] = 1'b1;
      cyc(3);
      chk("fresh source alerts", 0, alert_n);
      ph = 8'h01;
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_OK);
      chk("phase one cleared", 32'h1, status);
      ph = 8'hff;
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_OK);
      chk("persisting bit set again", 1, status[0]);
      cyc(2);
      chk("persisting fault alerts", 0, alert_n);
      src[0] = 1'b0;
      cyc(1);
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_OK);
      chk("all phases cleared", 0, status);
      // A latched-off output stays off across a fault clear.
      pin = 1'b1;
      cyc(6);
      chk("alert released again", 1, alert_n);
      chk("running before latch", 1, conv);
      latched = 1'b1;
      cyc(3);
      chk("latched off", 0, conv);
      cmd(8'h03, 1'b0, 1'b0, 8'h00, POFC_RSP_OK);
      cyc(4);
      chk("no restart on clear", 0, conv);
      end_sim();
   end
endmodule
